// *** rtl/lamp_pkg.sv ***
// Constants and types shared by the lamp brightness and switch control block
package lamp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Brightness code
  localparam int             LEVEL_W   = 5;
  localparam logic [LEVEL_W-1:0] LEVEL_MID = 5'h10;
  localparam logic [LEVEL_W-1:0] LEVEL_MAX = 5'h1f;
  localparam logic [LEVEL_W-1:0] LEVEL_MIN = 5'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Switching rate
  localparam int CLK_HZ      = 200_000_000;
  localparam int SLOW_HZ     = 145_000;
  localparam int FAST_HZ     = 290_000;
  localparam int PERIOD_SLOW = CLK_HZ / SLOW_HZ;
  localparam int PERIOD_FAST = CLK_HZ / FAST_HZ;
  localparam int CYC_W       = 11;
  localparam logic [CYC_W-1:0] LAST_SLOW = CYC_W'(PERIOD_SLOW - 1);
  localparam logic [CYC_W-1:0] LAST_FAST = CYC_W'(PERIOD_FAST - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser lanes
  localparam int PIN_UP    = 0;
  localparam int PIN_DOWN  = 1;
  localparam int PIN_PD    = 2;
  localparam int PIN_SYNC  = 3;
  localparam int PIN_REF   = 4;
  localparam int PIN_CS    = 5;
  localparam int PIN_OTP   = 6;
  localparam int PIN_COUNT = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam int          ADDR_W     = 12;
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h004;
  localparam int          CTRL_LAMP_ON = 0;
  localparam logic        CTRL_LAMP_ON_RESET = 1'b1;
  localparam int          ST_LEVEL     = 0;
  localparam int          ST_SWITCH    = 5;
  localparam int          ST_DISCHARGE = 6;
  localparam int          ST_SHUTDOWN  = 7;
  localparam int          ST_OTP       = 8;
  localparam int          ST_FAST      = 9;

  ////////////////////////////////////////////////////////////////////////////
  // Switch cycle states
  typedef enum logic [1:0] {
    CYC_IDLE = 2'b00,
    CYC_ON   = 2'b01,
    CYC_OFF  = 2'b11
  } cycle_state_t;

endpackage

// *** rtl/level_if.sv ***
// Step requests and brightness code between the top and the counter
`timescale 1ns/10ps
interface level_if;
  import lamp_pkg::*;
  logic               inc_edge;
  logic               dec_edge;
  logic               preset;
  logic [LEVEL_W-1:0] level;
  modport src (output inc_edge, output dec_edge, output preset, input level);
  modport cnt (input inc_edge, input dec_edge, input preset, output level);
endinterface

// *** rtl/edge_sync.sv ***
// Two-stage pin synchroniser with rising-edge detect
`timescale 1ns/10ps
module edge_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Raw pins
  input  wire logic [W-1:0] raw,
  // Synchronised levels and edges
  output logic      [W-1:0] lvl,
  output logic      [W-1:0] rise
);

  logic [W-1:0] meta;
  logic [W-1:0] prev;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_lvl;
  logic [W-1:0] next_prev;

  always_comb begin
    next_meta = raw;
    next_lvl  = meta;
    next_prev = lvl;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      lvl  <= '0;
      prev <= '0;
    end else begin
      meta <= next_meta;
      lvl  <= next_lvl;
      prev <= next_prev;
    end
  end

  // Edge seen only on the second stage
  assign rise = lvl & ~prev;

endmodule

// *** rtl/bright_counter.sv ***
// Saturating up/down brightness counter with mid-scale preset
`timescale 1ns/10ps
module bright_counter
  import lamp_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Step requests and code
  level_if.cnt      bus
);

  logic [LEVEL_W-1:0] level;
  logic [LEVEL_W-1:0] next_level;

  always_comb begin
    next_level = level;
    if (bus.preset) begin
      next_level = LEVEL_MID;
    end else if (bus.inc_edge && !bus.dec_edge && level != LEVEL_MAX) begin
      next_level = level + LEVEL_W'(1);
    end else if (bus.dec_edge && !bus.inc_edge && level != LEVEL_MIN) begin
      next_level = level - LEVEL_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level <= LEVEL_MID;
    end else begin
      level <= next_level;
    end
  end

  assign bus.level = level;

  chk_preset_mid: assert property (@(posedge clk) disable iff (!rst_n)
    bus.preset |=> level == LEVEL_MID) else $error("preset did not load mid-scale");

  chk_inc_step: assert property (@(posedge clk) disable iff (!rst_n)
    bus.inc_edge && !bus.dec_edge && !bus.preset && level != LEVEL_MAX |=> level == $past(level) + 5'h01)
    else $error("increment did not raise code by one");

  chk_dec_step: assert property (@(posedge clk) disable iff (!rst_n)
    bus.dec_edge && !bus.inc_edge && !bus.preset && level != LEVEL_MIN |=> level == $past(level) - 5'h01)
    else $error("decrement did not lower code by one");

  chk_no_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    !bus.preset && ((level == LEVEL_MAX && !bus.dec_edge) || (level == LEVEL_MIN && !bus.inc_edge))
    |=> $stable(level)) else $error("counter wrapped at an end");

endmodule

// *** rtl/lamp_brightness_switch_control.sv ***
// Lamp brightness counter, switch cycle control, soft-start and APB registers
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/10ps

// Function
// - Brightness is 5-bit code driving DAC
// - Power-on or both inputs high: mid-scale
// - Rising step-up edge raises code by one
// - Rising step-down edge lowers code by one
// - Code saturates at both ends, no wrap
// - Shutdown keeps the brightness code intact
// - Switch on each period, off on trip
// - Open-tube trip holds the switch off
// - Rate select picks 145kHz or 290kHz
// - Sync rising edge restarts cycle, switch on
// - Discharge at reset, code zero, shutdown, off
// - Charge soft-start whenever not discharging
// - Low shutdown pin enters low-power mode
module lamp_brightness_switch_control
  import lamp_pkg::*;
(
  // APB clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Host step and shutdown pins
  input  wire logic              step_up_in,
  input  wire logic              step_down_in,
  input  wire logic              power_down_n,
  // Rate select and sync comparators
  input  wire logic              freq_sel_ref,
  input  wire logic              freq_sel_pin,
  // Analog comparators
  input  wire logic              cs_trip,
  input  wire logic              otp_trip,
  // Lamp control outputs
  output logic      [LEVEL_W-1:0] dac_code,
  output logic                   switch_drive,
  output logic                   ss_discharge,
  output logic                   ss_charge,
  output logic                   low_power
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and brightness counter

  logic [PIN_COUNT-1:0] pin_raw;
  logic [PIN_COUNT-1:0] pin_lvl;
  logic [PIN_COUNT-1:0] pin_rise;

  assign pin_raw = {otp_trip, cs_trip, freq_sel_ref, freq_sel_pin,
                    power_down_n, step_down_in, step_up_in};

  edge_sync #(
    .W (PIN_COUNT)
  ) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .raw   (pin_raw),
    .lvl   (pin_lvl),
    .rise  (pin_rise)
  );

  level_if lvl_bus ();

  assign lvl_bus.inc_edge = pin_rise[PIN_UP];
  assign lvl_bus.dec_edge = pin_rise[PIN_DOWN];
  // Both pins high reloads mid-scale every cycle
  assign lvl_bus.preset   = pin_lvl[PIN_UP] & pin_lvl[PIN_DOWN];

  bright_counter u_cnt (
    .clk   (pclk),
    .rst_n (presetn),
    .bus   (lvl_bus.cnt)
  );

  assign dac_code = lvl_bus.level;

  logic shutdown;
  logic fast_rate;
  logic otp_hit;
  logic cs_hit;
  logic sync_rise;

  // Synchronisers reset low, so shutdown holds until the pin is seen
  assign shutdown  = ~pin_lvl[PIN_PD];
  assign fast_rate = pin_lvl[PIN_REF];
  assign otp_hit   = pin_lvl[PIN_OTP];
  assign cs_hit    = pin_lvl[PIN_CS];
  assign sync_rise = pin_rise[PIN_SYNC];

  ////////////////////////////////////////////////////////////////////////////
  // Soft-start and shutdown

  logic lamp_on;
  logic lamp_off;
  logic next_discharge;
  logic next_charge;
  logic next_low_power;

  // Lamp dark: code zero, shutdown or software off
  assign lamp_off = (lvl_bus.level == LEVEL_MIN) | shutdown | ~lamp_on;

  always_comb begin
    next_discharge = lamp_off;
    next_charge    = ~lamp_off;
    next_low_power = shutdown;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ss_discharge <= 1'b1;
      ss_charge    <= 1'b0;
      low_power    <= 1'b1;
    end else begin
      ss_discharge <= next_discharge;
      ss_charge    <= next_charge;
      low_power    <= next_low_power;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Switch cycle controller

  cycle_state_t     state;
  cycle_state_t     next_state;
  logic [CYC_W-1:0] cyc_cnt;
  logic [CYC_W-1:0] next_cyc_cnt;
  logic [CYC_W-1:0] cyc_last;
  logic             next_switch;
  logic             period_end;
  logic             cycle_start;
  logic             keep_on;

  assign cyc_last    = fast_rate ? LAST_FAST : LAST_SLOW;
  // Greater-or-equal covers a rate change mid-period
  assign period_end  = cyc_cnt >= cyc_last;
  assign cycle_start = sync_rise | period_end;

  always_comb begin
    keep_on = 1'b0;
    unique case (state)
      CYC_IDLE: keep_on = 1'b0;
      CYC_ON:   keep_on = ~cs_hit;
      CYC_OFF:  keep_on = 1'b0;
      default:  keep_on = 1'b0;
    endcase
    next_cyc_cnt = cycle_start ? '0 : cyc_cnt + CYC_W'(1);
    next_switch  = 1'b0;
    next_state   = CYC_IDLE;
    if (lamp_off) begin
      next_cyc_cnt = '0;
    end else begin
      // First cycle begins straight out of idle
      next_switch = ~otp_hit & (cycle_start | keep_on | (state == CYC_IDLE));
      next_state  = next_switch ? CYC_ON : CYC_OFF;
      if (state == CYC_IDLE) begin
        next_cyc_cnt = '0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state        <= CYC_IDLE;
      cyc_cnt      <= '0;
      switch_drive <= 1'b0;
    end else begin
      state        <= next_state;
      cyc_cnt      <= next_cyc_cnt;
      switch_drive <= next_switch;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave

  logic        acc_wr;
  logic        acc_rd_setup;
  logic        mapped;
  logic        next_lamp_on;
  logic [31:0] next_prdata;
  logic [31:0] status_word;

  assign mapped       = (paddr == OFS_CTRL) | (paddr == OFS_STATUS);
  assign acc_wr       = psel & penable & pwrite & (paddr == OFS_CTRL);
  assign acc_rd_setup = psel & ~penable & ~pwrite;
  assign pready       = 1'b1;
  assign pslverr      = psel & penable & ~mapped;

  always_comb begin
    status_word                       = '0;
    status_word[ST_LEVEL +: LEVEL_W]  = lvl_bus.level;
    status_word[ST_SWITCH]            = switch_drive;
    status_word[ST_DISCHARGE]         = ss_discharge;
    status_word[ST_SHUTDOWN]          = shutdown;
    status_word[ST_OTP]               = otp_hit;
    status_word[ST_FAST]              = fast_rate;
    next_lamp_on = acc_wr ? pwdata[CTRL_LAMP_ON] : lamp_on;
    next_prdata  = prdata;
    if (acc_rd_setup) begin
      if (paddr == OFS_CTRL) begin
        next_prdata = 32'h0000_0000;
        next_prdata[CTRL_LAMP_ON] = lamp_on;
      end else if (paddr == OFS_STATUS) begin
        next_prdata = status_word;
      end else begin
        next_prdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lamp_on <= CTRL_LAMP_ON_RESET;
      prdata  <= 32'h0000_0000;
    end else begin
      lamp_on <= next_lamp_on;
      prdata  <= next_prdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_otp_forces_off: assert property (@(posedge pclk) disable iff (!presetn)
    otp_hit |=> !switch_drive) else $error("switch on during open-tube trip");

  chk_period_turn_on: assert property (@(posedge pclk) disable iff (!presetn)
    period_end && !lamp_off && !otp_hit && state != CYC_IDLE |=> switch_drive && cyc_cnt == 11'h000)
    else $error("switch not on at period start");

  chk_cs_turn_off: assert property (@(posedge pclk) disable iff (!presetn)
    state == CYC_ON && cs_hit && !cycle_start |=> !switch_drive && state != CYC_ON)
    else $error("switch stayed on after current trip");

  chk_sync_restart: assert property (@(posedge pclk) disable iff (!presetn)
    sync_rise && !lamp_off && !otp_hit |=> switch_drive && cyc_cnt == 11'h000)
    else $error("sync edge did not restart cycle");

  chk_rate_period: assert property (@(posedge pclk) disable iff (!presetn)
    state != CYC_IDLE |-> cyc_cnt <= (fast_rate ? LAST_FAST : LAST_SLOW) || $changed(fast_rate) || $past(fast_rate) != fast_rate)
    else $error("period counter ran past its rate");

  chk_dark_idle: assert property (@(posedge pclk) disable iff (!presetn)
    lamp_off |=> ss_discharge && !ss_charge && !switch_drive && state == CYC_IDLE)
    else $error("dark lamp left switch or soft-start active");

  chk_charge_follows: assert property (@(posedge pclk) disable iff (!presetn)
    !lamp_off |=> ss_charge && !ss_discharge) else $error("soft-start not charging");

  chk_shutdown_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    shutdown && !lvl_bus.inc_edge && !lvl_bus.dec_edge && !lvl_bus.preset
    |=> $stable(lvl_bus.level) && low_power) else $error("shutdown disturbed code or mode");

  chk_idle_start: assert property (@(posedge pclk) disable iff (!presetn)
    state == CYC_IDLE && !lamp_off && !otp_hit |=> switch_drive && cyc_cnt == 11'h000)
    else $error("switch not on when leaving idle");

  chk_no_mid_on: assert property (@(posedge pclk) disable iff (!presetn)
    !switch_drive && !cycle_start && state != CYC_IDLE |=> !switch_drive)
    else $error("switch turned on in mid-period");

  chk_period_length: assert property (@(posedge pclk) disable iff (!presetn)
    period_end && !$changed(fast_rate) |-> cyc_cnt == (fast_rate ? LAST_FAST : LAST_SLOW))
    else $error("period ended at wrong count");

  chk_zero_dark: assert property (@(posedge pclk) disable iff (!presetn)
    lvl_bus.level == LEVEL_MIN |=> ss_discharge && !switch_drive)
    else $error("zero code left lamp running");

  chk_shutdown_off: assert property (@(posedge pclk) disable iff (!presetn)
    shutdown |=> low_power && !switch_drive && ss_discharge)
    else $error("shutdown left switch running");

  chk_wake_normal: assert property (@(posedge pclk) disable iff (!presetn)
    !shutdown |=> !low_power)
    else $error("low-power mode without shutdown");

  ////////////////////////////////////////////////////////////////////////////
  // Register checks

  chk_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pwrite && paddr == OFS_CTRL |=> lamp_on == $past(pwdata[CTRL_LAMP_ON]))
    else $error("lamp-on bit not written");

  chk_ctrl_read: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && paddr == OFS_CTRL |=> prdata[CTRL_LAMP_ON] == lamp_on)
    else $error("lamp-on bit read wrong");

  chk_status_code: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && paddr == OFS_STATUS |=> prdata[ST_LEVEL +: LEVEL_W] == $past(lvl_bus.level))
    else $error("status code read wrong");

endmodule

// *** tb/lamp_host_model.sv ***
// Host side model driving the step and shutdown pins
`timescale 1ns/10ps
module lamp_host_model (
  // Clock
  input  wire logic pclk,
  // Pins toward the block
  output logic      step_up_in,
  output logic      step_down_in,
  output logic      power_down_n
);
  initial begin
    step_up_in = 1'b0;
    step_down_in = 1'b0;
    power_down_n = 1'b1;
  end

  // Three cycles high and low so no edge is lost in the synchroniser
  task automatic drive(input logic up, input logic down);
    @(posedge pclk);
    step_up_in <= up;
    step_down_in <= down;
    repeat (3) @(posedge pclk);
    step_up_in <= 1'b0;
    step_down_in <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  task automatic set_power(input logic on);
    @(posedge pclk);
    power_down_n <= on;
  endtask
endmodule

// *** tb/lamp_brightness_switch_control_tb.sv ***
// Self-checking bench for the lamp brightness and switch control block
`timescale 1ns/10ps
module lamp_brightness_switch_control_tb;
  import lamp_pkg::*;
  localparam int LIMIT = 40000;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [ADDR_W-1:0]  paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic step_up_in, step_down_in, power_down_n, freq_sel_ref, freq_sel_pin;
  logic cs_trip, otp_trip, switch_drive, ss_discharge, ss_charge, low_power;
  logic [LEVEL_W-1:0] dac_code;
  int fails = 0;
  int cmp_count = 0;
  int cycles = 0;
  int seed = 45;
  int level = 16;
  int n, r;

  lamp_brightness_switch_control uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .step_up_in, .step_down_in, .power_down_n, .freq_sel_ref,
    .freq_sel_pin, .cs_trip, .otp_trip, .dac_code, .switch_drive, .ss_discharge, .ss_charge,
    .low_power);
  lamp_host_model host (.pclk, .step_up_in, .step_down_in, .power_down_n);

  initial pclk = 1'b0;
  always #2.5 pclk = ~pclk;

  always @(posedge pclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("Comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic tally(input string name, input logic ok, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (ok !== 1'b1) begin
      fails++;
      $display("Error %s expected %h seen %h", name, e, s);
    end
  endtask

  task automatic chk_bit(input string name, input logic e, input logic s);
    tally(name, s === e, 32'(e), 32'(s));
  endtask

  task automatic chk_code(input string name, input logic [LEVEL_W-1:0] e, input logic [LEVEL_W-1:0] s);
    tally(name, s === e, 32'(e), 32'(s));
  endtask

  task automatic chk_word(input string name, input logic [31:0] e, input logic [31:0] s);
    tally(name, s === e, e, s);
  endtask

  task automatic chk_lamp(input logic dark, input logic lp);
    chk_bit("ss_discharge", dark, ss_discharge);
    chk_bit("ss_charge", ~dark, ss_charge);
    chk_bit("low_power", lp, low_power);
    if (dark) begin
      chk_bit("dark_switch", 1'b0, switch_drive);
    end
  endtask

  task automatic idle(input int k);
    repeat (k) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Cycles until the next switch turn-on, seen at falling edges
  task automatic wait_rise(output int k);
    logic prev;
    k = 0;
    prev = switch_drive;
    forever begin
      @(negedge pclk);
      k++;
      if (switch_drive === 1'b1 && prev !== 1'b1) break;
      prev = switch_drive;
    end
  endtask

  task automatic step(input logic up, input logic down);
    host.drive(up, down);
    if (up && down) level = 16;
    else if (up) level = (level < 31) ? level + 1 : level;
    else if (down) level = (level > 0) ? level - 1 : level;
    @(negedge pclk);
    chk_code("level", 5'(level), dac_code);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    freq_sel_ref = 1'b0;
    freq_sel_pin = 1'b0;
    cs_trip = 1'b0;
    otp_trip = 1'b0;
    idle(8);
    chk_code("reset_code", 5'h10, dac_code);
    chk_lamp(1'b1, 1'b1);
    @(posedge pclk);
    presetn <= 1'b1;
    idle(8);
    chk_lamp(1'b0, 1'b0);
    chk_bit("switch_on", 1'b1, switch_drive);
    @(posedge pclk);
    cs_trip <= 1'b1;
    idle(4);
    chk_bit("switch_trip", 1'b0, switch_drive);
    wait_rise(n);
    wait_rise(n);
    chk_word("period_slow", 32'(PERIOD_SLOW), 32'(n));
    @(posedge pclk);
    freq_sel_ref <= 1'b1;
    wait_rise(n);
    wait_rise(n);
    chk_word("period_fast", 32'(PERIOD_FAST), 32'(n));
    @(posedge pclk);
    freq_sel_ref <= 1'b0;
    wait_rise(n);
    idle(100);
    @(posedge pclk);
    freq_sel_pin <= 1'b1;
    wait_rise(n);
    chk_word("sync_latency", 32'h4, 32'(n));
    wait_rise(n);
    chk_word("sync_period", 32'(PERIOD_SLOW), 32'(n));
    @(posedge pclk);
    freq_sel_pin <= 1'b0;
    otp_trip <= 1'b1;
    cs_trip <= 1'b0;
    idle(4);
    n = 0;
    repeat (PERIOD_SLOW + 20) begin
      @(negedge pclk);
      if (switch_drive !== 1'b0) n++;
    end
    chk_word("otp_hold", 32'd0, 32'(n));
    @(posedge pclk);
    otp_trip <= 1'b0;
    cs_trip <= 1'b1;
    apb(1'b0, OFS_CTRL, 32'h0);
    chk_word("ctrl_reset", 32'h1, rd);
    apb(1'b1, OFS_CTRL, 32'h0);
    idle(3);
    chk_lamp(1'b1, 1'b0);
    apb(1'b1, OFS_STATUS, 32'hffffffff);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk_word("status", {22'h0, 5'h02, 5'(level)}, rd);
    apb(1'b0, 12'h008, 32'h0);
    chk_bit("unmapped_err", 1'b1, err);
    chk_word("unmapped_rd", 32'h0, rd);
    apb(1'b1, OFS_CTRL, 32'hffffffff);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk_word("ctrl_rw", 32'h1, rd);
    repeat (20) step(1'b1, 1'b0);
    repeat (36) step(1'b0, 1'b1);
    idle(3);
    chk_lamp(1'b1, 1'b0);
    step(1'b1, 1'b1);
    host.set_power(1'b0);
    idle(4);
    chk_lamp(1'b1, 1'b1);
    step(1'b1, 1'b0);
    host.set_power(1'b1);
    idle(6);
    chk_lamp(1'b0, 1'b0);
    repeat (40) begin
      r = $random(seed);
      step(r[0], ~r[0] | r[1] & r[2]);
    end
    stop_test();
  end
endmodule
